// ===== rbe_defs.vh
// Constants for the reset and bus-fault exception unit.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
// How it works
// - A reset exception starts when the external reset pin or an internal module asks for one.
// - Reset wins over every other exception source, which is held off until reset ends.
// - Recognising reset drops whatever the core was doing, with nothing kept for resuming.
// - Reset clears both trace bits of the status word so tracing is off afterwards.
// - Reset sets the supervisor bit of the status word.
// - Reset loads the three-bit interrupt mask with all ones.
// - Reset clears the vector base pointer to zero.
// - Reset reads two long words from the reset vector, stack pointer then program counter, then fetches the first instruction.
// - Reset saves neither the old program counter nor the old status word.
// - A bus or address error during reset processing is a double fault that halts the core and raises the halt output.
// - The software reset instruction raises no reset exception and leaves core registers alone.
// - The software reset instruction resets ordinary peripheral registers but not integration or module control registers.
// - The software reset instruction drives the reset line so outside devices are reset by its completion.
// - A bus error exception arises only once an asserted bus fault has been acknowledged for a bus cycle.
// - The bus fault may come from the external pin, an internal module or the bus watchdog.
// - Bus error processing starts only when the core tries to use data from the aborted cycle.
`ifndef RBE_DEFS_VH
`define RBE_DEFS_VH
`define RBE_CLK_MHZ        200
`define RBE_SWRST_NS       640
`define RBE_SWRST_CYC      ((`RBE_SWRST_NS * `RBE_CLK_MHZ + 999) / 1000)
`define RBE_SR_T1_BIT      15
`define RBE_SR_T0_BIT      14
`define RBE_SR_S_BIT       13
`define RBE_SR_IPM_HI      10
`define RBE_SR_IPM_LO      8
`define RBE_SR_RESET       16'h2700
`define RBE_VBR_RESET      32'h0000_0000
`define RBE_RESET_VECNUM   8'h00
`define RBE_VEC_SP_OFS     32'h0000_0000
`define RBE_VEC_PC_OFS     32'h0000_0004
`endif

// ===== rbe_exc_unit.v
// Reset and bus-fault exception sequencer for the core.
// Assumes a simple one-outstanding read port to memory and pins resynced here.
`timescale 1ns/10ps
`include "rbe_defs.vh"
module rbe_exc_unit #(
    parameter SWRST_CYCLES = `RBE_SWRST_CYC
) (
    input  wire        mclk,
    input  wire        srst,
    input  wire        ext_reset_n,
    input  wire        int_reset_req,
    input  wire        ext_bus_fault_n,
    input  wire        int_bus_fault,
    input  wire        wdog_bus_fault,
    input  wire        bus_cycle_ack,
    input  wire        bus_data_use,
    input  wire        other_exc_req,
    input  wire        sw_reset_instr,
    input  wire        addr_error,
    input  wire        rd_ack,
    input  wire [31:0] rd_data,
    output reg         rd_req,
    output reg  [31:0] rd_addr,
    output reg         core_abort,
    output reg         fetch_start,
    output reg  [15:0] processor_status_word,
    output reg  [31:0] vector_base_pointer,
    output reg  [31:0] stack_pointer,
    output reg  [31:0] program_counter,
    output reg         halt_out,
    output reg         bus_err_exc,
    output wire        other_exc_grant,
    output reg         reset_out_oe,
    output reg         periph_soft_reset,
    output reg         sw_reset_done
);
    localparam ST_RUN   = 3'd0;
    localparam ST_RSP   = 3'd1;
    localparam ST_RPC   = 3'd2;
    localparam ST_FETCH = 3'd3;
    localparam ST_HALT  = 3'd4;
    localparam ST_SWRST = 3'd5;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [1:0]  ext_rst_sync_r;
    reg  [1:0]  ext_bf_sync_r;
    reg         fault_pend_r;
    reg  [15:0] swrst_cnt_r;
    wire        reset_req;
    wire        fault_any;

    // Pins pass two flops before use
    always @(posedge mclk) begin
        if (srst) begin
            ext_rst_sync_r <= 2'b00;
            ext_bf_sync_r  <= 2'b00;
        end else begin
            ext_rst_sync_r <= {ext_rst_sync_r[0], ~ext_reset_n};
            ext_bf_sync_r  <= {ext_bf_sync_r[0], ~ext_bus_fault_n};
        end
    end

    assign reset_req = ext_rst_sync_r[1] | int_reset_req;
    assign fault_any = ext_bf_sync_r[1] | int_bus_fault | wdog_bus_fault;
    // Lower exceptions wait while reset is pending or sequencing
    assign other_exc_grant = other_exc_req & ~reset_req & (state_r == ST_RUN);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:   if (sw_reset_instr) state_nxt = ST_SWRST;
            ST_RSP:   if (rd_ack) state_nxt = ST_RPC;
            ST_RPC:   if (rd_ack) state_nxt = ST_FETCH;
            ST_FETCH: state_nxt = ST_RUN;
            ST_HALT:  state_nxt = ST_HALT;
            ST_SWRST: if (swrst_cnt_r == 16'h0001) state_nxt = ST_RUN;
            default:  state_nxt = ST_RUN;
        endcase
        // Fault during vector reads is a double fault
        if ((state_r == ST_RSP || state_r == ST_RPC) && ((fault_any && bus_cycle_ack) || addr_error))
            state_nxt = ST_HALT;
        if (reset_req)
            state_nxt = ST_RSP;
    end

    always @(posedge mclk) begin
        if (srst) begin
            state_r               <= ST_RSP;
            rd_req                <= 1'b0;
            rd_addr               <= 32'h0000_0000;
            core_abort            <= 1'b1;
            fetch_start           <= 1'b0;
            processor_status_word <= `RBE_SR_RESET;
            vector_base_pointer   <= `RBE_VBR_RESET;
            stack_pointer         <= 32'h0000_0000;
            program_counter       <= 32'h0000_0000;
            halt_out              <= 1'b0;
            bus_err_exc           <= 1'b0;
            fault_pend_r          <= 1'b0;
            reset_out_oe          <= 1'b0;
            periph_soft_reset     <= 1'b0;
            sw_reset_done         <= 1'b0;
            swrst_cnt_r           <= 16'h0000;
        end else begin
            state_r       <= state_nxt;
            fetch_start   <= 1'b0;
            bus_err_exc   <= 1'b0;
            sw_reset_done <= 1'b0;
            core_abort    <= reset_req;
            if (reset_req) begin
                // Nothing stacked: old state simply overwritten
                processor_status_word[`RBE_SR_T1_BIT] <= 1'b0;
                processor_status_word[`RBE_SR_T0_BIT] <= 1'b0;
                processor_status_word[`RBE_SR_S_BIT]  <= 1'b1;
                processor_status_word[`RBE_SR_IPM_HI:`RBE_SR_IPM_LO] <= 3'b111;
                vector_base_pointer <= `RBE_VBR_RESET;
                halt_out          <= 1'b0;
                fault_pend_r      <= 1'b0;
                reset_out_oe      <= 1'b0;
                periph_soft_reset <= 1'b0;
                rd_req            <= 1'b0;
                // Reset vector sits at base plus vector number times four
                rd_addr <= `RBE_VBR_RESET + {22'h00_0000, `RBE_RESET_VECNUM, 2'b00}
                           + `RBE_VEC_SP_OFS;
            end else begin
                case (state_r)
                    ST_RSP: begin
                        rd_req <= ~rd_ack & (state_nxt == ST_RSP);
                        if (rd_ack) begin
                            stack_pointer <= rd_data;
                            rd_addr <= rd_addr - `RBE_VEC_SP_OFS + `RBE_VEC_PC_OFS;
                            rd_req  <= (state_nxt == ST_RPC);
                        end
                    end
                    ST_RPC: begin
                        rd_req <= ~rd_ack & (state_nxt == ST_RPC);
                        if (rd_ack)
                            program_counter <= rd_data;
                    end
                    ST_FETCH: fetch_start <= 1'b1;
                    ST_SWRST: begin
                        // Core registers untouched; only pin and peripherals
                        reset_out_oe      <= (swrst_cnt_r != 16'h0001);
                        periph_soft_reset <= 1'b0;
                        swrst_cnt_r       <= swrst_cnt_r - 16'h0001;
                        sw_reset_done     <= (swrst_cnt_r == 16'h0001);
                    end
                    ST_RUN: begin
                        if (sw_reset_instr) begin
                            reset_out_oe      <= 1'b1;
                            periph_soft_reset <= 1'b1;
                            swrst_cnt_r       <= SWRST_CYCLES[15:0];
                        end
                        // Fault is latched on ack, raised only on use
                        if (fault_pend_r && bus_data_use) begin
                            bus_err_exc  <= 1'b1;
                            fault_pend_r <= 1'b0;
                        end
                        // New fault in the same cycle as a use must not be lost
                        if (fault_any && bus_cycle_ack)
                            fault_pend_r <= 1'b1;
                    end
                    ST_HALT: begin
                        halt_out <= 1'b1;
                        rd_req   <= 1'b0;
                    end
                    default: rd_req <= 1'b0;
                endcase
                if (state_nxt == ST_HALT)
                    halt_out <= 1'b1;
            end
        end
    end
endmodule // rbe_exc_unit

// ===== rbe_mem_model.sv
// Vector memory on the far side of the read port.
// Assumes one request at a time; lat sets the answer delay.
`timescale 1ns/10ps
module rbe_mem_model (
    input wire        mclk,
    input wire [3:0]  lat,
    input wire        rd_req,
    input wire [31:0] rd_addr,
    output reg        rd_ack,
    output reg [31:0] rd_data
);
    reg [3:0] cnt_r = 4'h0;
    initial rd_ack = 1'b0;
    initial rd_data = 32'h0000_0000;
    always @(posedge mclk) begin
        rd_ack <= 1'b0;
        // Data toggles when idle so a stale value is never read as valid
        rd_data <= ~rd_data;
        if (rd_req && !rd_ack) begin
            cnt_r <= (cnt_r == lat) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r == lat) begin
                rd_ack <= 1'b1;
                rd_data <= rd_addr ^ 32'h0001_F000;
            end
        end
    end
endmodule // rbe_mem_model

// ===== rbe_exc_chk.sv
// Port properties of the exception unit.
// Assumes one clock, bound into every rbe_exc_unit.
`timescale 1ns/10ps
module rbe_exc_chk #(parameter SWRST_CYCLES = 4) (
    input wire mclk, srst, int_reset_req, addr_error, bus_data_use,
    input wire rd_req, rd_ack, core_abort, fetch_start, halt_out,
    input wire bus_err_exc, other_exc_grant, reset_out_oe, periph_soft_reset,
    input wire [31:0] rd_addr, rd_data, program_counter, vector_base_pointer,
    input wire [15:0] processor_status_word
);
    reg [15:0] oe_cnt_r;
    always @(posedge mclk)
        oe_cnt_r <= reset_out_oe ? oe_cnt_r + 16'h0001 : 16'h0000;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_pc_ack; rd_req && rd_ack && rd_addr == 32'h0000_0004; endsequence
    sequence s_prst; periph_soft_reset ##1 !periph_soft_reset; endsequence
    a_reset_state: assert property ($fell(srst) |-> processor_status_word == 16'h2700
        && vector_base_pointer == 32'h0000_0000) else $error("Reset state wrong");
    a_pc_fetch: assert property (s_pc_ack |=> program_counter == $past(rd_data)
        ##1 fetch_start) else $error("Fetch wrong");
    a_abort_req: assert property (int_reset_req |=> core_abort)
        else $error("No abort");
    a_reset_first: assert property (other_exc_grant |-> !core_abort)
        else $error("Grant during reset");
    a_double_fault: assert property (rd_req && addr_error |=> halt_out[*4])
        else $error("No halt");
    a_swrst_len: assert property ($fell(reset_out_oe) |-> oe_cnt_r == SWRST_CYCLES)
        else $error("Reset out length");
    a_swrst_start: assert property ($rose(reset_out_oe) |-> s_prst)
        else $error("Peripheral reset pulse");
    a_swrst_keep: assert property (reset_out_oe |=> $stable(program_counter)
        && $stable(processor_status_word)) else $error("Core regs changed");
    a_bus_fault_signal_late: assert property (bus_err_exc |-> $past(bus_data_use))
        else $error("Early bus error");
endmodule // rbe_exc_chk
bind rbe_exc_unit rbe_exc_chk #(.SWRST_CYCLES(SWRST_CYCLES)) rbe_exc_chk_inst (
    .mclk, .srst, .int_reset_req, .addr_error, .bus_data_use, .rd_req, .rd_ack,
    .core_abort, .fetch_start, .halt_out, .bus_err_exc, .other_exc_grant,
    .reset_out_oe, .periph_soft_reset, .rd_addr, .rd_data, .program_counter,
    .vector_base_pointer, .processor_status_word);

// ===== tb_top.sv
// Bench for the exception unit with the vector memory model.
// Assumes the checker is bound; reset output held 4 cycles here.
`timescale 1ns/10ps
module tb_top;
    reg mclk = 0, srst = 1, ext_reset_n = 1, int_reset_req = 0, ext_bus_fault_n = 1;
    reg int_bus_fault = 0, wdog_bus_fault = 0, bus_cycle_ack = 0, bus_data_use = 0;
    reg other_exc_req = 0, sw_reset_instr = 0, addr_error = 0;
    reg [3:0] lat = 0;
    wire rd_req, rd_ack, core_abort, fetch_start, halt_out, bus_err_exc, other_exc_grant;
    wire reset_out_oe, periph_soft_reset, sw_reset_done;
    wire [31:0] rd_addr, rd_data, vector_base_pointer, stack_pointer, program_counter;
    wire [15:0] processor_status_word;
    integer n_mismatch = 0, num_checks = 0, cyc = 0, i, k, j;
    reg [31:0] v;
    always #2.5 mclk = ~mclk;
    rbe_exc_unit #(.SWRST_CYCLES(4)) rbe_exc_unit_inst (.mclk, .srst, .ext_reset_n,
        .int_reset_req, .ext_bus_fault_n, .int_bus_fault, .wdog_bus_fault, .bus_cycle_ack,
        .bus_data_use, .other_exc_req, .sw_reset_instr, .addr_error, .rd_ack, .rd_data,
        .rd_req, .rd_addr, .core_abort, .fetch_start, .processor_status_word,
        .vector_base_pointer, .stack_pointer, .program_counter, .halt_out, .bus_err_exc,
        .other_exc_grant, .reset_out_oe, .periph_soft_reset, .sw_reset_done);
    rbe_mem_model rbe_mem_model_inst (.mclk, .lat, .rd_req, .rd_addr, .rd_ack, .rd_data);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tick; begin @(posedge mclk); #1; end endtask
    task boot_ok;
        begin
            i = 0;
            while (fetch_start !== 1'b1 && i < 80) begin tick; i = i + 1; end
            chk(stack_pointer, 32'h0001_F000);
            chk(program_counter, 32'h0001_F004);
            chk({16'h0000, processor_status_word}, 32'h0000_2700);
            chk(vector_base_pointer, 32'h0000_0000);
        end
    endtask
    task t_int_reset;
        begin
            lat = 3;
            @(posedge mclk) other_exc_req <= 1;
            tick;
            chk(other_exc_grant, 1);
            @(posedge mclk) int_reset_req <= 1;
            tick;
            chk({core_abort, other_exc_grant}, 2'b10);
            @(posedge mclk) int_reset_req <= 0;
            other_exc_req <= 0;
            boot_ok;
        end
    endtask
    task t_halt;
        begin
            lat = 6;
            @(posedge mclk) ext_reset_n <= 0;
            repeat (3) tick;
            @(posedge mclk) ext_reset_n <= 1;
            repeat (4) tick;
            i = 0;
            while (rd_req !== 1'b1 && i < 40) begin tick; i = i + 1; end
            @(posedge mclk) addr_error <= 1;
            @(posedge mclk) addr_error <= 0;
            #1 chk(halt_out, 1);
            @(posedge mclk) srst <= 1;
            @(posedge mclk) srst <= 0;
            #1 lat = 0;
            boot_ok;
            chk(halt_out, 0);
        end
    endtask
    task t_swreset;
        begin
            v = program_counter;
            @(posedge mclk) sw_reset_instr <= 1;
            @(posedge mclk) sw_reset_instr <= 0;
            #1 chk({reset_out_oe, periph_soft_reset}, 2'b11);
            k = 0;
            while (reset_out_oe === 1'b1 && k < 20) begin tick; k = k + 1; end
            chk(k, 4);
            chk(sw_reset_done, 1);
            chk(program_counter, v);
        end
    endtask
    task bus_fault_signal(input integer s);
        begin
            @(posedge mclk) int_bus_fault <= (s == 0);
            wdog_bus_fault <= (s == 1);
            ext_bus_fault_n <= (s != 2);
            repeat (3) @(posedge mclk);
            bus_cycle_ack <= 1;
            @(posedge mclk) bus_cycle_ack <= 0;
            {int_bus_fault, wdog_bus_fault, ext_bus_fault_n} <= 3'b001;
            repeat (3) tick;
            chk(bus_err_exc, 0);
            @(posedge mclk) bus_data_use <= 1;
            @(posedge mclk) bus_data_use <= 0;
            #1 chk(bus_err_exc, 1);
        end
    endtask
    task final_report;
        begin
            $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin n_mismatch = n_mismatch + 1; final_report; end
    end
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 0;
        boot_ok;
        t_int_reset;
        t_halt;
        t_swreset;
        for (j = 0; j < 3; j = j + 1) bus_fault_signal(j);
        final_report;
    end
endmodule // tb_top
